// File: bench/host_model.sv
// Host side model issuing configuration writes
`timescale 1ns/10ps
`default_nettype none
module host_model (
    input wire logic clk_sys,
    output logic cfgWrEn,
    output logic [monitor_config_pkg::CFG_WIDTH-1:0] cfgWrData
);
    import monitor_config_pkg::*;
    initial begin
        cfgWrEn = 1'b0;
        cfgWrData = 8'h00;
    end
    // One write: enable and data on a falling edge, then enable low and data inverted on the next
    task automatic write(input logic [CFG_WIDTH-1:0] d);
        @(negedge clk_sys);
        cfgWrEn = 1'b1;
        cfgWrData = d;
        @(negedge clk_sys);
        cfgWrEn = 1'b0;
        cfgWrData = ~d;
    endtask
endmodule
`default_nettype wire

// File: bench/monitor_config_lock_control_tb.sv
// Testbench for the configuration and lock block
`timescale 1ns/10ps
`default_nettype none
module monitor_config_lock_control_tb;
    import monitor_config_pkg::*;
    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    logic monitorCycleTick = 1'b0;
    logic spinupStart = 1'b0;
    logic tachPulse = 1'b0;
    logic spinupTimeoutDone = 1'b0;
    logic [STEP_CODE_WIDTH-1:0] remote2StepDelay = 3'h0;
    logic cfgWrEn, useProgrammedLimits, allFansMax, busTimeoutOff, supplyScale5v, pwmSpinupHigh;
    logic minTempDecreaseDue, minTempIncreaseDue;
    logic [CFG_WIDTH-1:0] cfgWrData, cfgRdData;
    int num_errors = 0;
    int total_checks = 0;
    int decCount = 0;
    int incCount = 0;
    always #10 clk_sys = ~clk_sys;
    always @(posedge clk_sys) begin
        decCount <= decCount + int'(minTempDecreaseDue);
        incCount <= incCount + int'(minTempIncreaseDue);
    end
    host_model hostU (.clk_sys, .cfgWrEn, .cfgWrData);
    monitor_config_lock_control dut_u (.clk_sys, .rst_n, .cfgWrEn, .cfgWrData, .cfgRdData, .remote2StepDelay,
        .monitorCycleTick, .spinupStart, .tachPulse, .spinupTimeoutDone, .useProgrammedLimits, .allFansMax,
        .busTimeoutOff, .supplyScale5v, .pwmSpinupHigh, .minTempDecreaseDue, .minTempIncreaseDue);
    task automatic end_sim;
        $display("Mismatches %0d, checks %0d", num_errors, total_checks);
        if (num_errors == 0 && total_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge clk_sys);
    endtask
    task automatic wr(input logic [7:0] d);
        hostU.write(d);
        cyc(2);
    endtask
    task automatic pulse(ref logic s);
        @(negedge clk_sys);
        s = 1'b1;
        @(negedge clk_sys);
        s = 1'b0;
    endtask
    task automatic outs(input logic [7:0] exp);
        check({4'h0, useProgrammedLimits, allFansMax, busTimeoutOff, supplyScale5v}, exp);
    endtask
    // Spin-up with two tach pulses, then the timeout
    task automatic spin(input logic afterTach);
        pulse(spinupStart);
        cyc(2);
        check({7'h0, pwmSpinupHigh}, 8'h01);
        pulse(tachPulse);
        pulse(tachPulse);
        cyc(2);
        check({7'h0, pwmSpinupHigh}, {7'h0, afterTach});
        pulse(spinupTimeoutDone);
        cyc(2);
        check({7'h0, pwmSpinupHigh}, 8'h00);
    endtask
    initial begin
        cyc(5);
        rst_n = 1'b1;
        cyc(2);
        check(cfgRdData, 8'h00);
        cyc(POWERUP_CYCLES + 10);
        check(cfgRdData, 8'h04);
        wr(8'hfd);
        check(cfgRdData, 8'hed);
        outs(8'h0f);
        wr(8'h00);
        outs(8'h00);
        spin(1'b0);
        wr(8'h20);
        spin(1'b1);
        for (int c = 0; c < 3; c++) begin
            int d0;
            int i0;
            d0 = decCount;
            i0 = incCount;
            remote2StepDelay = 3'(c);
            repeat (16 << c) begin
                pulse(monitorCycleTick);
                cyc(1);
            end
            cyc(3);
            check(8'(decCount - d0), 8'h04);
            check(8'(incCount - i0), 8'h02);
        end
        wr(8'h03);
        check(cfgRdData, 8'h07);
        wr(8'hf8);
        check(cfgRdData, 8'h2f);
        outs(8'h0c);
        wr(8'h00);
        check(cfgRdData, 8'h07);
        rst_n = 1'b0;
        cyc(2);
        rst_n = 1'b1;
        cyc(2);
        check(cfgRdData, 8'h00);
        end_sim;
    end
    initial begin
        #200000;
        num_errors++;
        end_sim;
    end
endmodule
`default_nettype wire

// File: bench/monitor_config_props.sv
// Checker for the configuration and lock block
`timescale 1ns/10ps
`default_nettype none
module monitor_config_props (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic cfgWrEn,
    input wire logic [monitor_config_pkg::CFG_WIDTH-1:0] cfgWrData,
    input wire logic [monitor_config_pkg::CFG_WIDTH-1:0] cfgRdData,
    input wire logic useProgrammedLimits,
    input wire logic allFansMax,
    input wire logic busTimeoutOff,
    input wire logic supplyScale5v,
    input wire logic pwmSpinupHigh,
    input wire logic spinupTimeoutDone
);
    import monitor_config_pkg::*;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    sequence spinEnd;
        pwmSpinupHigh && spinupTimeoutDone;
    endsequence
    go_output_a: assert property (useProgrammedLimits == cfgRdData[0]) else $error("go output wrong");
    fans_output_a: assert property (allFansMax == cfgRdData[3]) else $error("fans output wrong");
    timeout_output_a: assert property (busTimeoutOff == cfgRdData[6]) else $error("timeout output wrong");
    supply_output_a: assert property (supplyScale5v == cfgRdData[7]) else $error("supply output wrong");
    reserved_zero_a: assert property (!cfgRdData[4]) else $error("reserved bit set");
    lock_sticky_a: assert property (cfgRdData[1] |=> cfgRdData[1]) else $error("lock cleared");
    go_frozen_a: assert property (cfgRdData[1] |=> $stable(cfgRdData[0])) else $error("go changed");
    fans_write_a: assert property (cfgWrEn |-> ##2 cfgRdData[3] == $past(cfgWrData[3], 2))
        else $error("fans write lost");
    ready_sticky_a: assert property (cfgRdData[2] |=> cfgRdData[2]) else $error("ready fell");
    spin_end_a: assert property (spinEnd |-> ##2 !pwmSpinupHigh) else $error("spin not ended");
endmodule
bind monitor_config_lock_control monitor_config_props props_u (.clk_sys, .rst_n, .cfgWrEn, .cfgWrData,
    .cfgRdData, .useProgrammedLimits, .allFansMax, .busTimeoutOff, .supplyScale5v, .pwmSpinupHigh,
    .spinupTimeoutDone);
`default_nettype wire

// File: rtl/monitor_config_lock_control.sv
// Global monitor configuration register with write-once lock
`timescale 1ns/10ps
`default_nettype none
module monitor_config_lock_control (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic cfgWrEn,
    input wire logic [monitor_config_pkg::CFG_WIDTH-1:0] cfgWrData,
    output logic [monitor_config_pkg::CFG_WIDTH-1:0] cfgRdData,
    input wire logic [monitor_config_pkg::STEP_CODE_WIDTH-1:0] remote2StepDelay,
    input wire logic monitorCycleTick,
    input wire logic spinupStart,
    input wire logic tachPulse,
    input wire logic spinupTimeoutDone,
    output logic useProgrammedLimits,
    output logic allFansMax,
    output logic busTimeoutOff,
    output logic supplyScale5v,
    output logic pwmSpinupHigh,
    output logic minTempDecreaseDue,
    output logic minTempIncreaseDue
);
    import monitor_config_pkg::*;

    logic monitorGo_q;
    logic lock_q;
    logic powerUpDone_q;
    logic allFansMax_q;
    logic spinupDetectOff_q;
    logic busTimeoutOff_q;
    logic supplyScale_q;
    logic lockableWrEn;
    logic [$clog2(POWERUP_CYCLES+1)-1:0] powerUpCount_q;
    spin_state_type spinState_q;
    logic [1:0] tachCount_q;
    logic [CFG_WIDTH-1:0] cfgRdData_q;
    logic useProgrammedLimits_q;
    logic busTimeoutOff_out_q;
    logic supplyScale5v_q;
    logic allFansMax_out_q;
    logic pwmSpinupHigh_q;
    logic minTempDecreaseDue_q;
    logic minTempIncreaseDue_q;

    step_delay_if sd ();

    assign sd.code = remote2StepDelay;
    assign sd.cycleTick = monitorCycleTick;

    step_delay_timer u_step_delay (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .sd(sd.timer)
    );

    // Lockable fields take writes only until the lock is set; later writes vanish silently
    assign lockableWrEn = cfgWrEn && !lock_q;

    // Lock state only leaves on reset, which stands for a power cycle
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            lock_q <= CFG_RESET[BIT_LOCK];
        end else if (lockableWrEn) begin
            lock_q <= cfgWrData[BIT_LOCK];
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            monitorGo_q <= CFG_RESET[BIT_MONITOR_GO];
        end else if (lockableWrEn) begin
            monitorGo_q <= cfgWrData[BIT_MONITOR_GO];
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            busTimeoutOff_q <= CFG_RESET[BIT_BUS_TIMEOUT_OFF];
        end else if (lockableWrEn) begin
            busTimeoutOff_q <= cfgWrData[BIT_BUS_TIMEOUT_OFF];
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            supplyScale_q <= CFG_RESET[BIT_SUPPLY_SCALE];
        end else if (lockableWrEn) begin
            supplyScale_q <= cfgWrData[BIT_SUPPLY_SCALE];
        end
    end

    // Spin-up detection is not a lockable field, so it follows every write
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            spinupDetectOff_q <= CFG_RESET[BIT_SPINUP_DETECT_OFF];
        end else if (cfgWrEn) begin
            spinupDetectOff_q <= cfgWrData[BIT_SPINUP_DETECT_OFF];
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            allFansMax_q <= CFG_RESET[BIT_ALL_FANS_MAX];
        end else if (cfgWrEn) begin
            allFansMax_q <= cfgWrData[BIT_ALL_FANS_MAX];
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            powerUpCount_q <= '0;
            powerUpDone_q <= 1'b0;
        end else if (!powerUpDone_q) begin
            if (powerUpCount_q == ($clog2(POWERUP_CYCLES+1))'(POWERUP_CYCLES - 1)) begin
                powerUpDone_q <= 1'b1;
            end else begin
                powerUpCount_q <= powerUpCount_q + 1'b1;
            end
        end
    end

    // Spin-up ends on tach pulses unless detection is off, else at timeout
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            spinState_q <= SPIN_IDLE;
            tachCount_q <= 2'h0;
        end else begin
            case (spinState_q)
                SPIN_IDLE: begin
                    tachCount_q <= 2'h0;
                    if (spinupStart) begin
                        spinState_q <= SPIN_RUN;
                    end
                end
                SPIN_RUN: begin
                    if (spinupTimeoutDone) begin
                        spinState_q <= SPIN_IDLE;
                    end else if (tachPulse && !spinupDetectOff_q) begin
                        if (tachCount_q == 2'(SPINUP_TACH_PULSES - 1)) begin
                            spinState_q <= SPIN_IDLE;
                        end
                        tachCount_q <= tachCount_q + 2'h1;
                    end
                end
                default: spinState_q <= SPIN_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            cfgRdData_q <= CFG_RESET;
        end else begin
            cfgRdData_q[BIT_MONITOR_GO] <= monitorGo_q;
            cfgRdData_q[BIT_LOCK] <= lock_q;
            cfgRdData_q[BIT_POWERUP_DONE] <= powerUpDone_q;
            cfgRdData_q[BIT_ALL_FANS_MAX] <= allFansMax_q;
            cfgRdData_q[BIT_RESERVED] <= 1'b0;
            cfgRdData_q[BIT_SPINUP_DETECT_OFF] <= spinupDetectOff_q;
            cfgRdData_q[BIT_BUS_TIMEOUT_OFF] <= busTimeoutOff_q;
            cfgRdData_q[BIT_SUPPLY_SCALE] <= supplyScale_q;
        end
    end

    // Control outputs follow the register one edge later
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            useProgrammedLimits_q <= 1'b0;
            allFansMax_out_q <= 1'b0;
            busTimeoutOff_out_q <= 1'b0;
            supplyScale5v_q <= 1'b0;
        end else begin
            useProgrammedLimits_q <= monitorGo_q;
            allFansMax_out_q <= allFansMax_q;
            busTimeoutOff_out_q <= busTimeoutOff_q;
            supplyScale5v_q <= supplyScale_q;
        end
    end

    // PWM stays high for as long as a spin-up runs
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            pwmSpinupHigh_q <= 1'b0;
        end else begin
            pwmSpinupHigh_q <= (spinState_q == SPIN_RUN);
        end
    end

    // Step pulses are re-timed so that each output leaves a flop
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            minTempDecreaseDue_q <= 1'b0;
            minTempIncreaseDue_q <= 1'b0;
        end else begin
            minTempDecreaseDue_q <= sd.due[0];
            minTempIncreaseDue_q <= sd.due[1];
        end
    end

    assign cfgRdData = cfgRdData_q;
    assign useProgrammedLimits = useProgrammedLimits_q;
    assign allFansMax = allFansMax_out_q;
    assign busTimeoutOff = busTimeoutOff_out_q;
    assign supplyScale5v = supplyScale5v_q;
    assign pwmSpinupHigh = pwmSpinupHigh_q;
    assign minTempDecreaseDue = minTempDecreaseDue_q;
    assign minTempIncreaseDue = minTempIncreaseDue_q;
endmodule
`default_nettype wire

// File: rtl/monitor_config_pkg.sv
// Constants shared by the monitor configuration and lock logic
package monitor_config_pkg;
    localparam int CFG_WIDTH = 8;
    localparam int BIT_MONITOR_GO = 0;
    localparam int BIT_LOCK = 1;
    localparam int BIT_POWERUP_DONE = 2;
    localparam int BIT_ALL_FANS_MAX = 3;
    localparam int BIT_RESERVED = 4;
    localparam int BIT_SPINUP_DETECT_OFF = 5;
    localparam int BIT_BUS_TIMEOUT_OFF = 6;
    localparam int BIT_SUPPLY_SCALE = 7;
    localparam logic [7:0] CFG_RESET = 8'h00;
    localparam int CLK_PERIOD_NS = 20;
    localparam int POWERUP_TIME_NS = 10000;
    localparam int POWERUP_CYCLES = (POWERUP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int STEP_CODE_WIDTH = 3;
    localparam int STEP_COUNT_WIDTH = 11;
    localparam int DECREASE_BASE_CYCLES = 4;
    localparam int INCREASE_BASE_CYCLES = 8;
    localparam int SPINUP_TACH_PULSES = 2;
    typedef enum logic [1:0] {
        SPIN_IDLE = 2'b01,
        SPIN_RUN = 2'b10
    } spin_state_type;
endpackage

// File: rtl/step_delay_if.sv
// Carrier between the configuration block and its step delay timer
`timescale 1ns/10ps
`default_nettype none
interface step_delay_if;
    import monitor_config_pkg::*;
    logic [STEP_CODE_WIDTH-1:0] code;
    logic cycleTick;
    logic [1:0] due;
    modport timer (input code, input cycleTick, output due);
    modport ctrl (output code, output cycleTick, input due);
endinterface
`default_nettype wire

// File: rtl/step_delay_timer.sv
// Minimum-temperature adjustment delay timer, decrease and increase
`timescale 1ns/10ps
`default_nettype none
module step_delay_timer (
    input wire logic clk_sys,
    input wire logic rst_n,
    step_delay_if.timer sd
);
    import monitor_config_pkg::*;

    localparam logic [STEP_COUNT_WIDTH-1:0] BASE [2] = '{
        STEP_COUNT_WIDTH'(DECREASE_BASE_CYCLES), STEP_COUNT_WIDTH'(INCREASE_BASE_CYCLES)};

    // Entry 0 paces decreases, entry 1 increases; each code step doubles the span
    for (genvar i = 0; i < 2; i++) begin : g_dir
        logic [STEP_COUNT_WIDTH-1:0] count_q;
        logic [STEP_COUNT_WIDTH-1:0] span;
        logic due_q;
        assign span = BASE[i] << sd.code;
        always_ff @(posedge clk_sys or negedge rst_n) begin
            if (!rst_n) begin
                count_q <= '0;
                due_q <= 1'b0;
            end else begin
                due_q <= 1'b0;
                if (sd.cycleTick) begin
                    if (count_q + 11'h001 >= span) begin
                        count_q <= '0;
                        due_q <= 1'b1;
                    end else begin
                        count_q <= count_q + 11'h001;
                    end
                end
            end
        end
        assign sd.due[i] = due_q;
    end
endmodule
`default_nettype wire
